// ==== include/mode_pages_pkg.sv ====
// Purpose: constants and types for the configuration and user data mode pages
// Assumes: one 250 MHz clock, byte-wide page buffer reached over a plain register port
// Notes:   byte positions are page byte numbers; offsets are byte addresses
package mode_pages_pkg;
	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 10;
	localparam int          DATA_W      = 32;
	localparam logic [9:0]  ADDR_CTRL   = 10'h000;
	localparam logic [9:0]  ADDR_STAT   = 10'h004;
	localparam logic [9:0]  ADDR_SENSE  = 10'h008;
	localparam logic [9:0]  ADDR_CURSOR = 10'h00C;
	localparam logic [1:0]  BUF_SEL     = 2'h1;
	localparam int          CTRL_START  = 0;
	localparam int          CTRL_SELECT = 1;
	localparam int          CTRL_PAGE   = 8;
	localparam int          ST_BUSY     = 0;
	localparam int          ST_DONE     = 1;
	localparam int          ST_CHECK    = 2;
	localparam int          ST_CD       = 3;
	localparam int          ST_KEY      = 4;
	localparam int          ST_ASC      = 8;
	localparam int          ST_ASCQ     = 16;
	// ----------------------------------------------------------------
	// page layout
	// ----------------------------------------------------------------
	localparam int          PAGE_BYTES  = 42;
	localparam int          EXT_BYTES   = 32;
	localparam int          NAME_BYTES  = 20;
	localparam int          VALUE_BYTES = 16;
	localparam int          B_CODE      = 0;
	localparam int          B_LEN       = 1;
	localparam int          B_ATTR      = 2;
	localparam int          B_RSV3      = 3;
	localparam int          B_NAME      = 4;
	localparam int          B_RSV24     = 24;
	localparam int          B_VALUE     = 25;
	localparam int          B_RSV41     = 41;
	localparam int          B_EXT       = 2;
	localparam logic [5:0]  PAGE_CFG    = 6'h3D;
	localparam logic [5:0]  PAGE_EXT    = 6'h3E;
	localparam logic [7:0]  LEN_CFG     = 8'h28;
	localparam logic [7:0]  LEN_EXT     = 8'h20;
	localparam logic [1:0]  PS_SET      = 2'h2;
	localparam logic [7:0]  ZERO_BYTE   = 8'h00;
	// attribute byte: write flag, type code, length
	localparam int          ATTR_WR     = 7;
	localparam int          ATTR_TYPE   = 4;
	localparam int          ATTR_LEN    = 0;
	localparam logic [2:0]  TYPE_ASCII  = 3'h0;
	localparam logic [2:0]  TYPE_BYTES  = 3'h1;
	localparam logic [2:0]  TYPE_SIGNED = 3'h2;
	localparam logic [2:0]  TYPE_UNSIGN = 3'h3;
	// ----------------------------------------------------------------
	// error reporting
	// ----------------------------------------------------------------
	localparam logic [3:0]  KEY_ILLEGAL = 4'h5;
	localparam logic [7:0]  ASC_BAD_CDB = 8'h24;
	localparam logic [7:0]  ASCQ_NONE   = 8'h00;
	localparam logic [15:0] FPTR_PAGE   = 16'h0002;
	// ----------------------------------------------------------------
	// variable table defaults
	// ----------------------------------------------------------------
	localparam int          NUM_VARS_DEF = 4;
	localparam logic [23:0] NAME_PREFIX  = 24'h564152;
	localparam logic [7:0]  NAME_DIGIT0  = 8'h30;
	localparam logic [31:0] ATTR_INIT_DEF = 32'hB2249880;

	typedef enum logic [1:0] {
		ENG_IDLE  = 2'b00,
		ENG_FIND  = 2'b01,
		ENG_APPLY = 2'b10
	} eng_state_t;
endpackage

// ==== include/var_table_if.sv ====
// Purpose: link between the page engine and the variable table
// Assumes: match result is registered one cycle after find_valid
// Notes:   read port is combinational from table flip-flops
`timescale 1ns/1ps
`default_nettype none
interface var_table_if #(parameter int NUM_VARS = 4, parameter int IDX_W = 2);
	logic [159:0]     find_name;
	logic             find_valid;
	logic             match_hit;
	logic [IDX_W-1:0] match_idx;
	logic [IDX_W-1:0] rd_idx;
	logic [159:0]     rd_name;
	logic [7:0]       rd_attr;
	logic [127:0]     rd_value;
	logic             wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [127:0]     wr_value;

	modport table_side (input find_name, find_valid, rd_idx, wr_en, wr_idx, wr_value,
		output match_hit, match_idx, rd_name, rd_attr, rd_value);
	modport engine_side (output find_name, find_valid, rd_idx, wr_en, wr_idx, wr_value,
		input match_hit, match_idx, rd_name, rd_attr, rd_value);
endinterface
`default_nettype wire

// ==== hdl/config_var_table.sv ====
// Purpose: configuration variable store kept in name order
// Assumes: default names are ascending, so index order is name order
// Notes:   only writable entries accept a new value
`timescale 1ns/1ps
`default_nettype none
module config_var_table #(
	parameter int                      NUM_VARS  = mode_pages_pkg::NUM_VARS_DEF,
	parameter int                      IDX_W     = 2,
	parameter logic [NUM_VARS*8-1:0]   ATTR_INIT = mode_pages_pkg::ATTR_INIT_DEF
) (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	// engine link
	var_table_if.table_side tbl
);
	import mode_pages_pkg::*;

	logic [159:0]        name_r  [NUM_VARS];
	logic [7:0]          attr_r  [NUM_VARS];
	logic [127:0]        value_r [NUM_VARS];
	logic [NUM_VARS-1:0] eq;
	logic                hit_nxt;
	logic [IDX_W-1:0]    idx_nxt;

	// ----------------------------------------------------------------
	// per entry storage
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_VARS; i++) begin : g_entry
		localparam logic [7:0] DIGIT = NAME_DIGIT0 + 8'(i);
		always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				name_r[i]  <= {NAME_PREFIX, DIGIT, 128'h0};
				attr_r[i]  <= ATTR_INIT[i*8 +: 8];
				value_r[i] <= 128'h0;
			end else if (tbl.wr_en && tbl.wr_idx == IDX_W'(i) && attr_r[i][ATTR_WR]) begin
				value_r[i] <= tbl.wr_value;
			end
		end
		assign eq[i] = (name_r[i] == tbl.find_name);
	end

	// ----------------------------------------------------------------
	// name lookup
	// ----------------------------------------------------------------
	always_comb begin
		hit_nxt = 1'b0;
		idx_nxt = '0;
		for (int k = NUM_VARS - 1; k >= 0; k--) begin
			if (eq[k]) begin
				hit_nxt = 1'b1;
				idx_nxt = IDX_W'(k);
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tbl.match_hit <= 1'b0;
			tbl.match_idx <= '0;
		end else if (tbl.find_valid) begin
			tbl.match_hit <= hit_nxt;
			tbl.match_idx <= idx_nxt;
		end
	end

	assign tbl.rd_name  = name_r[tbl.rd_idx];
	assign tbl.rd_attr  = attr_r[tbl.rd_idx];
	assign tbl.rd_value = value_r[tbl.rd_idx];
endmodule
`default_nettype wire

// ==== hdl/mode_page_engine.sv ====
// Purpose: answers mode select and mode sense for the configuration and external data pages
// Assumes: firmware moves page bytes through the buffer and starts one command at a time
// Notes:   a command takes three cycles; buffer writes are ignored while busy
//
// Contract
// - select by name, next sense returns it
// - each further sense returns next variable
// - config page code 3Dh, savable flag set
// - config page list length 28h
// - write flag shows variable is changeable
// - type codes ascii, bytes, signed, unsigned
// - zero length ascii is terminated string
// - byte array length gives byte count
// - signed integers 1, 2, 4 bytes msb first
// - unsigned integers 1, 2, 4 bytes msb first
// - length zero for terminated ascii strings
// - name in bytes 4 to 23, terminated
// - value bytes 25 to 40, read by attributes
// - 32 byte user memory never self-modified
// - only external select alters user memory
// - external page code 3Eh, savable flag set
// - external list length 20h, data bytes 2-33
// - unsupported page gives illegal request sense
`timescale 1ns/1ps
`default_nettype none
module mode_page_engine #(
	parameter int NUM_VARS = mode_pages_pkg::NUM_VARS_DEF
) (
	// clock and reset
	input  wire logic                               clk_sys_i,
	input  wire logic                               sys_rst_i,
	// register port
	input  wire logic [mode_pages_pkg::ADDR_W-1:0]  reg_addr_i,
	input  wire logic [mode_pages_pkg::DATA_W-1:0]  reg_wdata_i,
	input  wire logic                               reg_wr_i,
	input  wire logic                               reg_rd_i,
	output logic      [mode_pages_pkg::DATA_W-1:0]  reg_rdata_o,
	// status
	output logic                                    busy_o
);
	import mode_pages_pkg::*;

	localparam int IDX_W = (NUM_VARS > 1) ? $clog2(NUM_VARS) : 1;

	eng_state_t                     state_r;
	logic                           op_sel_r;
	logic [5:0]                     page_r;
	logic [PAGE_BYTES-1:0][7:0]     buf_r;
	logic [EXT_BYTES-1:0][7:0]      ext_r;
	logic [IDX_W-1:0]               cursor_r;
	logic                           done_r;
	logic                           check_r;
	logic [3:0]                     key_r;
	logic [7:0]                     asc_r;
	logic [7:0]                     ascq_r;
	logic [15:0]                    fptr_r;
	logic [DATA_W-1:0]              rdata_r;
	logic [5:0]                     buf_idx;
	logic                           buf_hit;
	logic                           start;
	logic                           apply;
	logic                           cfg_sense;
	logic                           cfg_select;
	logic                           ext_sense;
	logic                           ext_select;
	logic                           bad_page;
	logic [159:0]                   name_packed;
	logic [127:0]                   value_packed;

	var_table_if #(.NUM_VARS(NUM_VARS), .IDX_W(IDX_W)) vif ();

	config_var_table #(
		.NUM_VARS (NUM_VARS),
		.IDX_W    (IDX_W)
	) u_table (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.tbl       (vif.table_side)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	assign buf_idx    = reg_addr_i[7:2];
	assign buf_hit    = (reg_addr_i[9:8] == BUF_SEL) && (reg_addr_i[1:0] == 2'h0) && (int'(buf_idx) < PAGE_BYTES);
	assign start      = reg_wr_i && (reg_addr_i == ADDR_CTRL) && reg_wdata_i[CTRL_START] && (state_r == ENG_IDLE);
	assign apply      = (state_r == ENG_APPLY);
	assign cfg_sense  = apply && !op_sel_r && (page_r == PAGE_CFG);
	assign cfg_select = apply && op_sel_r && (page_r == PAGE_CFG);
	assign ext_sense  = apply && !op_sel_r && (page_r == PAGE_EXT);
	assign ext_select = apply && op_sel_r && (page_r == PAGE_EXT);
	assign bad_page   = apply && (page_r != PAGE_CFG) && (page_r != PAGE_EXT);
	assign busy_o     = (state_r != ENG_IDLE);

	// name and value fields of the buffer, first page byte in the top bits
	always_comb begin
		name_packed  = '0;
		value_packed = '0;
		for (int k = 0; k < NAME_BYTES; k++) begin
			name_packed[159-8*k -: 8] = buf_r[B_NAME+k];
		end
		for (int k = 0; k < VALUE_BYTES; k++) begin
			value_packed[127-8*k -: 8] = buf_r[B_VALUE+k];
		end
	end

	assign vif.find_name  = name_packed;
	assign vif.find_valid = (state_r == ENG_FIND);
	assign vif.rd_idx     = cursor_r;
	assign vif.wr_en      = cfg_select && vif.match_hit && buf_r[B_ATTR][ATTR_WR];
	assign vif.wr_idx     = vif.match_idx;
	assign vif.wr_value   = value_packed;

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r  <= ENG_IDLE;
			op_sel_r <= 1'b0;
			page_r   <= 6'h00;
		end else begin
			unique case (state_r)
				ENG_IDLE: begin
					if (start) begin
						state_r  <= ENG_FIND;
						op_sel_r <= reg_wdata_i[CTRL_SELECT];
						page_r   <= reg_wdata_i[CTRL_PAGE +: 6];
					end
				end
				ENG_FIND: begin
					state_r <= ENG_APPLY;
				end
				ENG_APPLY: begin
					state_r <= ENG_IDLE;
				end
				default: begin
					state_r <= ENG_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// variable cursor
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cursor_r <= '0;
		end else if (cfg_select && vif.match_hit) begin
			cursor_r <= vif.match_idx;
		end else if (cfg_sense) begin
			if (cursor_r == IDX_W'(NUM_VARS - 1)) begin
				cursor_r <= '0;
			end else begin
				cursor_r <= cursor_r + IDX_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// page buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			buf_r <= '0;
		end else if (cfg_sense) begin
			buf_r             <= '0;
			buf_r[B_CODE]     <= {PS_SET, PAGE_CFG};
			buf_r[B_LEN]      <= LEN_CFG;
			buf_r[B_ATTR]     <= vif.rd_attr;
			for (int k = 0; k < NAME_BYTES; k++) begin
				buf_r[B_NAME+k] <= vif.rd_name[159-8*k -: 8];
			end
			for (int k = 0; k < VALUE_BYTES; k++) begin
				buf_r[B_VALUE+k] <= vif.rd_value[127-8*k -: 8];
			end
		end else if (ext_sense) begin
			buf_r         <= '0;
			buf_r[B_CODE] <= {PS_SET, PAGE_EXT};
			buf_r[B_LEN]  <= LEN_EXT;
			buf_r[B_EXT+EXT_BYTES-1:B_EXT] <= ext_r;
		end else if (reg_wr_i && buf_hit && (state_r == ENG_IDLE)) begin
			buf_r[buf_idx] <= reg_wdata_i[7:0];
		end
	end

	// ----------------------------------------------------------------
	// user memory
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_r <= '0;
		end else if (ext_select) begin
			ext_r <= buf_r[B_EXT+EXT_BYTES-1:B_EXT];
		end
	end

	// ----------------------------------------------------------------
	// completion and sense data
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			done_r  <= 1'b0;
			check_r <= 1'b0;
			key_r   <= 4'h0;
			asc_r   <= 8'h00;
			ascq_r  <= 8'h00;
			fptr_r  <= 16'h0000;
		end else if (start) begin
			done_r  <= 1'b0;
			check_r <= 1'b0;
			key_r   <= 4'h0;
			asc_r   <= 8'h00;
			ascq_r  <= 8'h00;
			fptr_r  <= 16'h0000;
		end else if (apply) begin
			done_r <= 1'b1;
			if (bad_page) begin
				check_r <= 1'b1;
				key_r   <= KEY_ILLEGAL;
				asc_r   <= ASC_BAD_CDB;
				ascq_r  <= ASCQ_NONE;
				fptr_r  <= FPTR_PAGE;
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_r <= '0;
		end else if (reg_rd_i) begin
			rdata_r <= '0;
			if (reg_addr_i == ADDR_STAT) begin
				rdata_r[ST_BUSY]       <= busy_o;
				rdata_r[ST_DONE]       <= done_r;
				rdata_r[ST_CHECK]      <= check_r;
				rdata_r[ST_CD]         <= check_r;
				rdata_r[ST_KEY +: 4]   <= key_r;
				rdata_r[ST_ASC +: 8]   <= asc_r;
				rdata_r[ST_ASCQ +: 8]  <= ascq_r;
			end else if (reg_addr_i == ADDR_SENSE) begin
				rdata_r[15:0] <= fptr_r;
			end else if (reg_addr_i == ADDR_CURSOR) begin
				rdata_r[IDX_W-1:0] <= cursor_r;
			end else if (buf_hit) begin
				rdata_r[7:0] <= buf_r[buf_idx];
			end
		end else begin
			rdata_r <= '0;
		end
	end

	assign reg_rdata_o = rdata_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence seq_start;
		start;
	endsequence

	sequence seq_walk;
		(state_r == ENG_FIND) ##1 (state_r == ENG_APPLY) ##1 (done_r && !busy_o);
	endsequence

	AST_START_FLOW: assert property (seq_start |=> seq_walk)
		else $error("command did not complete in three cycles");
	AST_SELECT_POINT: assert property (cfg_select && vif.match_hit |=> cursor_r == $past(vif.match_idx))
		else $error("select did not point cursor at named variable");
	AST_CURSOR_STEP: assert property (cfg_sense && cursor_r != IDX_W'(NUM_VARS - 1)
		|=> cursor_r == $past(cursor_r) + IDX_W'(1))
		else $error("sense did not advance cursor");
	AST_CFG_CODE: assert property (cfg_sense |=> buf_r[B_CODE] == {PS_SET, PAGE_CFG})
		else $error("config page code byte wrong");
	AST_CFG_LEN: assert property (cfg_sense |=> buf_r[B_LEN] == LEN_CFG)
		else $error("config page length wrong");
	AST_CFG_ATTR: assert property (cfg_sense |=> buf_r[B_ATTR] == $past(vif.rd_attr))
		else $error("attribute byte not from table");
	AST_RSV_ZERO: assert property (cfg_sense |=> buf_r[B_RSV3] == ZERO_BYTE && buf_r[B_RSV24] == ZERO_BYTE
		&& buf_r[B_RSV41] == ZERO_BYTE)
		else $error("reserved byte not zero");
	AST_EXT_HOLD: assert property (!ext_select |=> $stable(ext_r))
		else $error("user memory changed without select");
	AST_EXT_WRITE: assert property (ext_select |=> ext_r == $past(buf_r[B_EXT+EXT_BYTES-1:B_EXT]))
		else $error("user memory not loaded by select");
	AST_EXT_CODE: assert property (ext_sense |=> buf_r[B_CODE] == {PS_SET, PAGE_EXT})
		else $error("external page code byte wrong");
	AST_EXT_SENSE: assert property (ext_sense |=> buf_r[B_LEN] == LEN_EXT
		&& buf_r[B_EXT+EXT_BYTES-1:B_EXT] == $past(ext_r))
		else $error("external page content wrong");
	AST_BAD_PAGE: assert property (bad_page |=> check_r && key_r == KEY_ILLEGAL && asc_r == ASC_BAD_CDB
		&& fptr_r == FPTR_PAGE)
		else $error("unsupported page not reported");
endmodule
`default_nettype wire

// ==== test/mode_host_model.sv ====
// Purpose: initiator model driving the register port of the mode page block
// Assumes: one request at a time; gap_cyc adds idle cycles before each request
// Notes:   read data are taken one step after the edge that follows the read strobe
`timescale 1ns/1ps
`default_nettype none
module mode_host_model (
	// clock
	input  wire logic                              clk_sys_i,
	// register port
	output logic      [mode_pages_pkg::ADDR_W-1:0] reg_addr_o,
	output logic      [mode_pages_pkg::DATA_W-1:0] reg_wdata_o,
	output logic                                   reg_wr_o,
	output logic                                   reg_rd_o,
	input  wire logic [mode_pages_pkg::DATA_W-1:0] reg_rdata_i,
	// status
	input  wire logic                              busy_i
);
	import mode_pages_pkg::*;
	int gap_cyc = 0;

	initial begin
		reg_addr_o = '0;
		reg_wdata_o = '0;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	function automatic logic [9:0] buf_addr(input int i);
		return 10'h100 + 10'(4 * i);
	endfunction

	task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
		repeat (gap_cyc + 1) @(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
	endtask

	task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
		repeat (gap_cyc + 1) @(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_o <= 1'b0;
		#1;
		d = reg_rdata_i;
	endtask

	// start a command and count the cycles busy stays up
	task automatic cmd(input logic sel, input logic [5:0] page, output int hi);
		bus_wr(ADDR_CTRL, {18'h0, page, 6'h0, sel, 1'b1});
		hi = 0;
		#1;
		while (busy_i === 1'b1 && hi < 8) begin
			@(posedge clk_sys_i);
			#1;
			hi++;
		end
	endtask

	// selection page: name zero filled through byte 23, value from base upward
	task automatic load_cfg(input logic [31:0] name4, input logic wflag, input logic [7:0] base);
		bus_wr(buf_addr(B_ATTR), {24'h0, wflag, 7'h0});
		for (int i = 0; i < NAME_BYTES; i++)
			bus_wr(buf_addr(B_NAME + i), {24'h0, i < 4 ? name4[31-8*i -: 8] : 8'h00});
		for (int i = 0; i < VALUE_BYTES; i++)
			bus_wr(buf_addr(B_VALUE + i), {24'h0, base + 8'(i)});
	endtask
endmodule
`default_nettype wire

// ==== test/test_config_and_user_data_mode_pages.sv ====
// Purpose: self-checking bench for the configuration and user data mode pages
// Assumes: default variable table of four entries
// Notes:   ordinary sense cases run from a row table, the rest by hand
`timescale 1ns/1ps
`default_nettype none
module test_config_and_user_data_mode_pages;
	import mode_pages_pkg::*;
	typedef struct {
		logic [5:0] page;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
	} row_t;
	logic              clk_sys_i = 1'b0;
	logic              sys_rst_i = 1'b1;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic [DATA_W-1:0] reg_rdata;
	logic              reg_wr;
	logic              reg_rd;
	logic              busy;
	logic [31:0]       d;
	int                hi;
	int                err_total = 0;
	int                cmp_count = 0;
	row_t              rows [6] = '{
		'{PAGE_CFG, 8'hBD, 8'h28, 8'h80},
		'{PAGE_CFG, 8'hBD, 8'h28, 8'h98},
		'{PAGE_CFG, 8'hBD, 8'h28, 8'h24},
		'{PAGE_CFG, 8'hBD, 8'h28, 8'hB2},
		'{PAGE_CFG, 8'hBD, 8'h28, 8'h80},
		'{PAGE_EXT, 8'hBE, 8'h20, 8'h00}};

	always #2 clk_sys_i = ~clk_sys_i;

	mode_page_engine dut (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.reg_addr_i  (reg_addr),
		.reg_wdata_i (reg_wdata),
		.reg_wr_i    (reg_wr),
		.reg_rd_i    (reg_rd),
		.reg_rdata_o (reg_rdata),
		.busy_o      (busy)
	);

	mode_host_model host (
		.clk_sys_i   (clk_sys_i),
		.reg_addr_o  (reg_addr),
		.reg_wdata_o (reg_wdata),
		.reg_wr_o    (reg_wr),
		.reg_rd_o    (reg_rd),
		.reg_rdata_i (reg_rdata),
		.busy_i      (busy)
	);

	// ----------------------------------------------------------------
	// checking helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
		host.bus_rd(a, d);
		check(d, exp);
	endtask

	task automatic run(input logic sel, input logic [5:0] page);
		host.cmd(sel, page, hi);
		check(hi, 2);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rchk(ADDR_CURSOR, 32'h0);
		rchk(10'h3FC, 32'h0);
		foreach (rows[r]) begin
			run(1'b0, rows[r].page);
			rchk(host.buf_addr(B_CODE), 32'(rows[r].b0));
			rchk(host.buf_addr(B_LEN), 32'(rows[r].b1));
			rchk(host.buf_addr(B_ATTR), 32'(rows[r].b2));
			rchk(host.buf_addr(B_RSV41), 32'h0);
			if (rows[r].page == PAGE_CFG) begin
				rchk(host.buf_addr(B_RSV3), 32'h0);
				rchk(host.buf_addr(B_NAME + 3), 32'h30 + r % 4);
				rchk(host.buf_addr(B_RSV24), 32'h0);
				rchk(ADDR_CURSOR, (r + 1) % 4);
			end
		end
		// select each variable with the write flag, read-only one must keep its value
		for (int v = 0; v < 4; v++) begin
			host.load_cfg({NAME_PREFIX, NAME_DIGIT0 + 8'(v)}, 1'b1, 8'(16 * v + 1));
			run(1'b1, PAGE_CFG);
			rchk(ADDR_CURSOR, v);
			run(1'b0, PAGE_CFG);
			rchk(ADDR_CURSOR, (v + 1) % 4);
			rchk(host.buf_addr(B_NAME + 3), NAME_DIGIT0 + v);
			for (int k = 0; k < VALUE_BYTES; k++)
				rchk(host.buf_addr(B_VALUE + k), ATTR_INIT_DEF[8*v+7] ? 16 * v + 1 + k : 0);
		end
		// unknown name leaves cursor and values alone
		host.load_cfg(32'h56415258, 1'b1, 8'hA0);
		run(1'b1, PAGE_CFG);
		rchk(ADDR_CURSOR, 32'h0);
		run(1'b0, PAGE_CFG);
		rchk(host.buf_addr(B_VALUE), 32'h1);
		// write flag clear in the select page leaves a writable variable alone
		host.load_cfg({NAME_PREFIX, NAME_DIGIT0}, 1'b0, 8'hC0);
		run(1'b1, PAGE_CFG);
		rchk(ADDR_CURSOR, 32'h0);
		run(1'b0, PAGE_CFG);
		rchk(host.buf_addr(B_VALUE), 32'h1);
		// user memory with a slow host; config traffic must not touch it
		host.gap_cyc = 3;
		for (int i = 2; i < 34; i++)
			host.bus_wr(host.buf_addr(i), 32'(i + 128));
		run(1'b1, PAGE_EXT);
		host.load_cfg({NAME_PREFIX, NAME_DIGIT0}, 1'b1, 8'h55);
		run(1'b1, PAGE_CFG);
		run(1'b0, PAGE_CFG);
		run(1'b0, PAGE_EXT);
		host.gap_cyc = 0;
		for (int i = 0; i < PAGE_BYTES; i++)
			rchk(host.buf_addr(i), i == 0 ? 32'hBE : i == 1 ? 32'h20 : i < 34 ? 32'(i + 128) : 32'h0);
		// unsupported page codes in both directions
		for (int p = 0; p < 4; p++) begin
			host.bus_wr(host.buf_addr(B_CODE), 32'h5A);
			run(p[0], p < 2 ? 6'h3F : 6'h00);
			host.bus_rd(ADDR_STAT, d);
			check(d & 32'h00FF_FFFC, 32'h0000_245C);
			rchk(ADDR_SENSE, 32'(FPTR_PAGE));
			rchk(host.buf_addr(B_CODE), 32'h5A);
		end
		// a buffer write landing while a command runs is dropped
		host.bus_wr(ADDR_CTRL, {18'h0, 6'h3F, 8'h01});
		host.bus_wr(host.buf_addr(B_CODE), 32'hA5);
		rchk(host.buf_addr(B_CODE), 32'h5A);
		run(1'b0, PAGE_EXT);
		rchk(ADDR_STAT, 32'h2);
		host.bus_wr(10'h3FC, 32'hFFFF_FFFF);
		rchk(10'h3FC, 32'h0);
		// second reset in mid-run
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rchk(ADDR_CURSOR, 32'h0);
		run(1'b0, PAGE_EXT);
		rchk(host.buf_addr(B_EXT), 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
